/* File: rtl/psreg_pkg.sv */
// command register map, option encodings and reset values of the power
// stage command register bank; used by the design, the bench keeps its own literals
package psreg_pkg;

  // =====================================================================
  // stored registers: code, reset value, word or byte wide
  localparam int NREG = 29;
  // linear formats: 5-bit exponent, 11-bit mantissa
  localparam logic [15:0] SLEW_0203  = 16'hd00d;
  localparam logic [15:0] SLEW_1953  = 16'hd07d;
  localparam logic [15:0] SLEW_29218 = 16'hd0bb;
  localparam logic [15:0] SLEW_9375  = 16'hd258;
  localparam logic [15:0] SCALE_QTR  = 16'hf001;
  localparam logic [15:0] SCALE_HALF = 16'hf002;
  localparam logic [15:0] SCALE_ONE  = 16'hf004;

  localparam logic [7:0] REG_CODE [NREG] = '{
    8'h01, 8'h02, 8'h10, 8'h1b, 8'h21, 8'h24, 8'h25, 8'h26, 8'h27, 8'h29,
    8'h33, 8'h35, 8'h36, 8'h37, 8'h41, 8'h43, 8'h45, 8'h46, 8'h47, 8'h4a,
    8'h4b, 8'h4f, 8'h50, 8'h51, 8'h55, 8'h56, 8'h60, 8'h61, 8'h62};
  localparam logic [15:0] REG_RST [NREG] = '{
    16'h0000, 16'h0017, 16'h0000, 16'h0000, 16'h0000, 16'h0b00,
    16'h06cd, 16'h0667, SLEW_0203, SCALE_HALF, 16'h092c, 16'hf80c,
    16'hf80b, 16'h0000, 16'h0040, 16'h0067, 16'h0040, 16'h081b,
    16'h0080, 16'he200, 16'h000e, 16'h008c, 16'h00c0, 16'h0073,
    16'h080a, 16'h00c0, 16'h0001, 16'h0005, 16'h0806};
  localparam logic REG_WIDE [NREG] = '{
    1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1,
    1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1,
    1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};

  // index of entries that the logic looks at
  localparam int IDX_RUN   = 0;
  localparam int IDX_ONOFF = 1;
  localparam int IDX_LOCK  = 2;
  localparam int IDX_MASK  = 3;
  localparam int IDX_VCMD  = 4;
  localparam int IDX_SLEW  = 8;
  localparam int IDX_SCALE = 9;
  localparam int IDX_ROLE  = 13;
  localparam int IDX_PEAK  = 17;
  localparam int IDX_AVGW  = 19;
  localparam int IDX_NEG   = 20;
  localparam int IDX_VINOV = 25;

  // =====================================================================
  // commands without storage
  localparam logic [7:0] CMD_CLEAR   = 8'h03;
  localparam logic [7:0] CMD_SAVE    = 8'h15;
  localparam logic [7:0] CMD_LOAD    = 8'h16;
  localparam logic [7:0] CMD_FEATURE = 8'h19;
  localparam logic [7:0] CMD_FORMAT  = 8'h20;
  localparam logic [7:0] FEATURE_VAL = 8'hb0;
  localparam logic [7:0] FORMAT_VAL  = 8'h17;

  // =====================================================================
  // field positions and codes
  localparam int ONOFF_PU   = 4;
  localparam int ONOFF_CMD  = 3;
  localparam int ONOFF_PIN  = 2;
  localparam int ONOFF_POL  = 1;
  localparam int RUN_ON     = 7;
  localparam logic [7:0] LOCK_ALL  = 8'h80;
  localparam logic [7:0] LOCK_RUN  = 8'h40;
  localparam logic [7:0] LOCK_CFG  = 8'h20;
  localparam logic [7:0] BLK_COUNT = 8'h01;
  localparam logic [15:0] ROLE_MAX = 16'h0003;
  localparam logic [7:0] ACT_LOW_MASK = 8'h3f;
  localparam logic [7:0] CRC_POLY  = 8'h07;
  localparam int FLT_CML = 0;

endpackage : psreg_pkg

/* File: rtl/psreg_bank.sv */
// power stage command register bank: stored settings, fault latching,
// alert gating and the packet check byte for the management bus.
// assumes a transaction engine that decodes frames into one-cycle
// command strobes and feeds every frame byte to the check byte engine.
`timescale 1ns/1ps

module psreg_bank #(
  parameter int FLT_W = 8
) (
  input  wire logic        clock_in,
  input  wire logic        resetn_in,
  input  wire logic [7:0]  cmd_in,
  input  wire logic        wr_in,
  input  wire logic        wr_block_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        rd_in,
  input  wire logic        rd_block_in,
  input  wire logic        enable_pin_in,
  input  wire logic [FLT_W-1:0] fault_src_in,
  input  wire logic        crc_clr_in,
  input  wire logic        crc_valid_in,
  input  wire logic [7:0]  crc_byte_in,
  output logic      [15:0] rd_data_out,
  output logic             rd_valid_out,
  output logic             regulate_out,
  output logic      [15:0] slew_out,
  output logic      [15:0] fb_ratio_out,
  output logic      [1:0]  phase_role_out,
  output logic      [1:0]  vin_ov_action_out,
  output logic      [FLT_W-1:0] fault_status_out,
  output logic             alert_out,
  output logic             nvm_save_out,
  output logic             nvm_load_out,
  output logic      [7:0]  pec_out
);

  // =====================================================================
  // decode
  localparam int N = psreg_pkg::NREG;

  logic [15:0]      regs_ff [N];
  logic [N-1:0]     hit;
  logic             known;
  logic [15:0]      wval;
  logic             blk_ok;
  logic             lock_ok;
  logic             val_ok;
  logic             wr_ok;
  logic             bad_wr;
  logic             bad_rd;
  logic             clear_evt;
  logic [FLT_W-1:0] flt_now;
  logic [FLT_W-1:0] fault_lat_ff;
  logic [FLT_W-1:0] nxt_fault_lat;
  logic [15:0]      nxt_rd_data;
  logic [7:0]       rd_byte;
  logic [7:0]       crc_ff;
  logic             rd_valid_ff;
  logic             save_ff;
  logic             load_ff;

  genvar g;
  for (g = 0; g < N; g++) begin : g_hit
    assign hit[g] = (cmd_in == psreg_pkg::REG_CODE[g]);
  end
  assign known = |hit;

  // block write: low byte is the count, high byte the data
  assign blk_ok = !wr_block_in ||
                  (wdata_in[7:0] == psreg_pkg::BLK_COUNT);
  assign wval   = wr_block_in ? {8'h00, wdata_in[15:8]} : wdata_in;

  // lock levels widen what stays writable as the code goes down
  always_comb begin
    logic [7:0] lk;
    lk = regs_ff[psreg_pkg::IDX_LOCK][7:0];
    lock_ok = 1'b1;
    if (lk == psreg_pkg::LOCK_ALL) begin
      lock_ok = hit[psreg_pkg::IDX_LOCK];
    end else if (lk == psreg_pkg::LOCK_RUN) begin
      lock_ok = hit[psreg_pkg::IDX_LOCK] | hit[psreg_pkg::IDX_RUN];
    end else if (lk == psreg_pkg::LOCK_CFG) begin
      lock_ok = hit[psreg_pkg::IDX_LOCK] | hit[psreg_pkg::IDX_RUN] |
                hit[psreg_pkg::IDX_ONOFF] | hit[psreg_pkg::IDX_VCMD];
    end
  end

  // option-set registers refuse anything outside their list
  always_comb begin
    val_ok = 1'b1;
    if (hit[psreg_pkg::IDX_SLEW]) begin
      val_ok = (wval == psreg_pkg::SLEW_0203) ||
               (wval == psreg_pkg::SLEW_1953) ||
               (wval == psreg_pkg::SLEW_29218) ||
               (wval == psreg_pkg::SLEW_9375);
    end else if (hit[psreg_pkg::IDX_SCALE]) begin
      val_ok = (wval == psreg_pkg::SCALE_QTR) ||
               (wval == psreg_pkg::SCALE_HALF) ||
               (wval == psreg_pkg::SCALE_ONE);
    end else if (hit[psreg_pkg::IDX_ROLE]) begin
      val_ok = (wval <= psreg_pkg::ROLE_MAX);
    end else if (hit[psreg_pkg::IDX_VINOV]) begin
      val_ok = (wval[15:8] == 8'h00) &&
               ((wval[7:0] & psreg_pkg::ACT_LOW_MASK) == 8'h00);
    end
  end

  // the host is trusted to stop regulation before setting writes and
  // store/load; nothing here refuses them while running
  assign clear_evt = wr_in && (cmd_in == psreg_pkg::CMD_CLEAR) && blk_ok;
  assign wr_ok = wr_in && known && blk_ok && lock_ok && val_ok;
  assign bad_wr = wr_in && !wr_ok && !clear_evt &&
                  !(blk_ok && (cmd_in == psreg_pkg::CMD_SAVE ||
                               cmd_in == psreg_pkg::CMD_LOAD));
  // reads of write-only or unknown codes also count as comm faults
  assign bad_rd = rd_in && !known &&
                  (cmd_in != psreg_pkg::CMD_FEATURE) &&
                  (cmd_in != psreg_pkg::CMD_FORMAT);

  // =====================================================================
  // storage
  for (g = 0; g < N; g++) begin : g_reg
    always_ff @(posedge clock_in) begin
      if (!resetn_in) begin
        regs_ff[g] <= psreg_pkg::REG_RST[g];
      end else if (wr_ok && hit[g]) begin
        regs_ff[g] <= psreg_pkg::REG_WIDE[g] ? wval : {8'h00, wval[7:0]};
      end
    end
  end

  // =====================================================================
  // read back
  always_comb begin
    rd_byte = 8'h00;
    nxt_rd_data = 16'h0000;
    if (cmd_in == psreg_pkg::CMD_FEATURE) begin
      nxt_rd_data = {8'h00, psreg_pkg::FEATURE_VAL};
    end else if (cmd_in == psreg_pkg::CMD_FORMAT) begin
      nxt_rd_data = {8'h00, psreg_pkg::FORMAT_VAL};
    end
    for (int i = 0; i < N; i++) begin
      if (hit[i] && i != psreg_pkg::IDX_MASK) begin
        nxt_rd_data = regs_ff[i];
      end
    end
    rd_byte = nxt_rd_data[7:0];
    if (rd_block_in) begin
      nxt_rd_data = {rd_byte, psreg_pkg::BLK_COUNT};
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      rd_data_out <= 16'h0000;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_valid_ff <= rd_in;
      if (rd_in) begin
        rd_data_out <= nxt_rd_data;
      end
    end
  end
  assign rd_valid_out = rd_valid_ff;

  // =====================================================================
  // fault latching and alert
  always_comb begin
    flt_now = fault_src_in;
    flt_now[psreg_pkg::FLT_CML] = fault_src_in[psreg_pkg::FLT_CML] |
                                  bad_wr | bad_rd;
    // a fault still present or arriving in the clear cycle survives
    if (clear_evt) begin
      nxt_fault_lat = flt_now;
    end else begin
      nxt_fault_lat = fault_lat_ff | flt_now;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      fault_lat_ff <= '0;
    end else begin
      fault_lat_ff <= nxt_fault_lat;
    end
  end

  assign fault_status_out = fault_lat_ff;
  // mask bit set means that source never raises the alert
  assign alert_out = |(fault_lat_ff &
                       ~regs_ff[psreg_pkg::IDX_MASK][FLT_W-1:0]);

  // =====================================================================
  // nonvolatile store requests
  always_ff @(posedge clock_in) begin
    if (!resetn_in) begin
      save_ff <= 1'b0;
      load_ff <= 1'b0;
    end else begin
      save_ff <= wr_in && blk_ok && (cmd_in == psreg_pkg::CMD_SAVE);
      load_ff <= wr_in && blk_ok && (cmd_in == psreg_pkg::CMD_LOAD);
    end
  end
  assign nvm_save_out = save_ff;
  assign nvm_load_out = load_ff;

  // =====================================================================
  // setting outputs
  always_comb begin
    logic [7:0] oc;
    logic       cmd_ok;
    logic       pin_ok;
    oc = regs_ff[psreg_pkg::IDX_ONOFF][7:0];
    cmd_ok = !oc[psreg_pkg::ONOFF_CMD] ||
             regs_ff[psreg_pkg::IDX_RUN][psreg_pkg::RUN_ON];
    pin_ok = !oc[psreg_pkg::ONOFF_PIN] ||
             (enable_pin_in == oc[psreg_pkg::ONOFF_POL]);
    // with the power-up bit clear the stage runs whenever supplied
    regulate_out = !oc[psreg_pkg::ONOFF_PU] || (cmd_ok && pin_ok);
  end

  assign slew_out          = regs_ff[psreg_pkg::IDX_SLEW];
  assign fb_ratio_out      = regs_ff[psreg_pkg::IDX_SCALE];
  assign phase_role_out    = regs_ff[psreg_pkg::IDX_ROLE][1:0];
  assign vin_ov_action_out = regs_ff[psreg_pkg::IDX_VINOV][7:6];

  // =====================================================================
  // packet check byte, msb first, no reflection
  function automatic logic [7:0] crc_step(input logic [7:0] c,
                                          input logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int b = 0; b < 8; b++) begin
      x = x[7] ? ((x << 1) ^ psreg_pkg::CRC_POLY) : (x << 1);
    end
    return x;
  endfunction : crc_step

  always_ff @(posedge clock_in) begin
    if (!resetn_in || crc_clr_in) begin
      crc_ff <= 8'h00;
    end else if (crc_valid_in) begin
      crc_ff <= crc_step(crc_ff, crc_byte_in);
    end
  end
  assign pec_out = crc_ff;

  // =====================================================================
  // checks
  sequence s_bad_write;
    wr_in && !wr_ok && !clear_evt && known;
  endsequence

  sequence s_clean_clear;
    clear_evt && !(|fault_src_in) && !bad_rd;
  endsequence

  // the host leaves one idle edge between the clear and the first byte
  sequence s_crc_one_byte;
    crc_clr_in ##1 (!crc_clr_in && !crc_valid_in)
      ##1 (crc_valid_in && crc_byte_in == 8'h01 && !crc_clr_in);
  endsequence

  chk_onoff_reset: assert property (@(posedge clock_in)
    $rose(resetn_in) |-> regs_ff[psreg_pkg::IDX_ONOFF] == 16'h0017)
    else $error("power-on source config not at its reset value");

  chk_feature_read: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    rd_in && !rd_block_in && cmd_in == psreg_pkg::CMD_FEATURE
      |=> rd_valid_out && rd_data_out == 16'h00b0)
    else $error("feature report read wrong");

  chk_mask_gate: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    fault_src_in[1] && !regs_ff[psreg_pkg::IDX_MASK][1] &&
      !(wr_in && hit[psreg_pkg::IDX_MASK]) |=> alert_out)
    else $error("unmasked fault did not raise the alert");

  chk_slew_legal: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    slew_out inside {16'hd00d, 16'hd07d, 16'hd0bb, 16'hd258})
    else $error("slew register holds an illegal encoding");

  chk_ratio_legal: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    fb_ratio_out inside {16'hf001, 16'hf002, 16'hf004})
    else $error("divider ratio holds an illegal value");

  chk_role_range: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    regs_ff[psreg_pkg::IDX_ROLE][15:2] == 14'h0000)
    else $error("phase role outside four roles");

  chk_limit_reset: assert property (@(posedge clock_in)
    $rose(resetn_in) |-> regs_ff[psreg_pkg::IDX_PEAK] == 16'h081b &&
      regs_ff[psreg_pkg::IDX_NEG] == 16'h000e &&
      regs_ff[psreg_pkg::IDX_AVGW] == 16'he200)
    else $error("current limits not at reset values");

  chk_vinov_opts: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    $rose(resetn_in) or regs_ff[psreg_pkg::IDX_VINOV][5:0] == 6'h00)
    else $error("input overvolt action not a listed choice");

  chk_block_count: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    wr_in && wr_block_in && wdata_in[7:0] != 8'h01
      |=> fault_status_out[psreg_pkg::FLT_CML])
    else $error("bad block count not flagged");

  chk_pec_clear: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    s_crc_one_byte |=> pec_out == 8'h07)
    else $error("check byte engine wrong");

  chk_bad_write: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    s_bad_write |=> fault_status_out[psreg_pkg::FLT_CML] &&
      $stable(slew_out) && $stable(fb_ratio_out))
    else $error("illegal write changed a register or went unflagged");

  chk_clear_release: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    s_clean_clear |=> fault_status_out == '0 && !alert_out)
    else $error("fault clear did not release the alert");

  chk_lock_hold: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    wr_in && hit[psreg_pkg::IDX_SLEW] &&
      regs_ff[psreg_pkg::IDX_LOCK][7:0] == psreg_pkg::LOCK_ALL
      |=> $stable(slew_out) && fault_status_out[psreg_pkg::FLT_CML])
    else $error("locked write changed a setting or went unflagged");

  chk_clear_keeps: assert property (@(posedge clock_in)
    disable iff (!resetn_in)
    clear_evt && fault_src_in[2] |=> fault_status_out[2])
    else $error("fault still present was dropped by the clear");

endmodule : psreg_bank

/* File: dv/psreg_host_model.sv */
// management bus host model: drives command strobes and frame bytes
// assumes the bank samples on rising edges; this model moves on falling
`timescale 1ns/1ps

module psreg_host_model (
  input  wire logic        clock_in,
  input  wire logic [15:0] rd_data_in,
  input  wire logic        rd_valid_in,
  output logic      [7:0]  cmd_out,
  output logic             wr_out,
  output logic             wr_block_out,
  output logic      [15:0] wdata_out,
  output logic             rd_out,
  output logic             rd_block_out,
  output logic             crc_clr_out,
  output logic             crc_valid_out,
  output logic      [7:0]  crc_byte_out
);
  // =====================================================================
  // idle lines
  initial begin
    cmd_out = 8'h00;
    wdata_out = 16'h0000;
    crc_byte_out = 8'h00;
    wr_out = 1'b0;
    wr_block_out = 1'b0;
    rd_out = 1'b0;
    rd_block_out = 1'b0;
    crc_clr_out = 1'b0;
    crc_valid_out = 1'b0;
  end

  // released strobes drop and data lines flip so a stale value never passes for fresh data
  task automatic release_bus();
    wr_out = 1'b0;
    wr_block_out = 1'b0;
    rd_out = 1'b0;
    rd_block_out = 1'b0;
    crc_clr_out = 1'b0;
    crc_valid_out = 1'b0;
    cmd_out = ~cmd_out;
    wdata_out = ~wdata_out;
    crc_byte_out = ~crc_byte_out;
  endtask : release_bus

  // =====================================================================
  // register transfers
  task automatic write(input logic [7:0] c, input logic [15:0] d,
                       input logic b);
    @(negedge clock_in);
    cmd_out = c;
    wdata_out = d;
    wr_block_out = b;
    wr_out = 1'b1;
    @(negedge clock_in);
    release_bus();
  endtask : write

  task automatic blk_wr(input logic [7:0] c, input logic [7:0] d);
    write(c, {d, 8'h01}, 1'b1);
  endtask : blk_wr

  // regulation is stopped before any setting is changed
  task automatic stop_run();
    write(8'h01, 16'h0000, 1'b0);
  endtask : stop_run

  task automatic read(input logic [7:0] c, input logic b,
                      output logic [15:0] q);
    int i;
    @(negedge clock_in);
    cmd_out = c;
    rd_block_out = b;
    rd_out = 1'b1;
    @(negedge clock_in);
    release_bus();
    q = 16'hxxxx;
    for (i = 0; i < 4; i++) begin
      if (rd_valid_in === 1'b1) begin
        q = rd_data_in;
        break;
      end
      @(negedge clock_in);
    end
  endtask : read

  // every frame byte is handed over, address byte included
  task automatic crc_send(input logic [7:0] d, input logic clr);
    @(negedge clock_in);
    crc_byte_out = d;
    crc_clr_out = clr;
    crc_valid_out = ~clr;
    @(negedge clock_in);
    release_bus();
  endtask : crc_send
endmodule : psreg_host_model

/* File: dv/tb_top.sv */
// self-checking bench of the command register bank
// assumes the host model owns the register port and the frame bytes
`timescale 1ns/1ps

module tb_top;
  typedef struct packed {
    logic [7:0]  c;
    logic [15:0] d;
    logic [15:0] e;
    logic        f;
  } psreg_row_t;

  logic        clock_in;
  logic        resetn_in;
  logic        enable_pin_in;
  logic [7:0]  fault_src_in;
  logic [7:0]  cmd, crc_byte, flt, pec, c;
  logic [15:0] wdata, rd_data, slew, ratio, got;
  logic        wr, wr_blk, rd, rd_blk, crc_clr, crc_vld;
  logic        rd_valid, regulate, alert, nvm_save, nvm_load;
  logic [1:0]  role, vin_act;
  int          mismatches;
  int          checked;
  int          saves = 0;
  int          loads = 0;

  localparam logic [7:0] RST_C [11] = '{8'h02, 8'h19, 8'h27, 8'h29,
    8'h37, 8'h46, 8'h4b, 8'h4a, 8'h56, 8'h01, 8'h1b};
  localparam logic [15:0] RST_E [11] = '{16'h0017, 16'h00b0, 16'hd00d,
    16'hf002, 16'h0000, 16'h081b, 16'h000e, 16'he200, 16'h00c0,
    16'h0000, 16'h0000};
  localparam psreg_row_t ROWS [17] = '{
    '{8'h27, 16'hd07d, 16'hd07d, 1'b0}, '{8'h27, 16'hd0bb, 16'hd0bb, 1'b0},
    '{8'h27, 16'hd258, 16'hd258, 1'b0}, '{8'h27, 16'h1234, 16'hd258, 1'b1},
    '{8'h29, 16'hf001, 16'hf001, 1'b0}, '{8'h29, 16'hf004, 16'hf004, 1'b0},
    '{8'h29, 16'hf003, 16'hf004, 1'b1}, '{8'h37, 16'h0003, 16'h0003, 1'b0},
    '{8'h37, 16'h0002, 16'h0002, 1'b0}, '{8'h37, 16'h0001, 16'h0001, 1'b0},
    '{8'h37, 16'h0004, 16'h0001, 1'b1}, '{8'h56, 16'h0000, 16'h0000, 1'b0},
    '{8'h56, 16'h0040, 16'h0040, 1'b0}, '{8'h56, 16'h00c1, 16'h0040, 1'b1},
    '{8'h56, 16'h00c0, 16'h00c0, 1'b0}, '{8'h19, 16'h0012, 16'h00b0, 1'b1},
    '{8'h7f, 16'h1234, 16'h0000, 1'b1}};
  localparam logic [7:0] FRAME [4] = '{8'hb4, 8'h27, 8'h7d, 8'hd0};

  psreg_bank u_psreg_bank (.clock_in(clock_in), .resetn_in(resetn_in),
    .cmd_in(cmd), .wr_in(wr), .wr_block_in(wr_blk), .wdata_in(wdata),
    .rd_in(rd), .rd_block_in(rd_blk), .enable_pin_in(enable_pin_in),
    .fault_src_in(fault_src_in), .crc_clr_in(crc_clr),
    .crc_valid_in(crc_vld), .crc_byte_in(crc_byte),
    .rd_data_out(rd_data), .rd_valid_out(rd_valid),
    .regulate_out(regulate), .slew_out(slew), .fb_ratio_out(ratio),
    .phase_role_out(role), .vin_ov_action_out(vin_act),
    .fault_status_out(flt), .alert_out(alert), .nvm_save_out(nvm_save),
    .nvm_load_out(nvm_load), .pec_out(pec));

  psreg_host_model u_host (.clock_in(clock_in), .rd_data_in(rd_data),
    .rd_valid_in(rd_valid), .cmd_out(cmd), .wr_out(wr),
    .wr_block_out(wr_blk), .wdata_out(wdata), .rd_out(rd),
    .rd_block_out(rd_blk), .crc_clr_out(crc_clr),
    .crc_valid_out(crc_vld), .crc_byte_out(crc_byte));

  initial begin
    clock_in = 1'b0;
    forever #20 clock_in = ~clock_in;
  end

  always @(posedge clock_in) begin
    saves <= saves + int'(nvm_save);
    loads <= loads + int'(nvm_load);
  end

  // =====================================================================
  // helpers
  function automatic logic [7:0] crc8(logic [7:0] s, logic [7:0] d);
    s = s ^ d;
    for (int i = 0; i < 8; i++) begin
      s = s[7] ? ({s[6:0], 1'b0} ^ 8'h07) : {s[6:0], 1'b0};
    end
    return s;
  endfunction : crc8

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic clear();
    u_host.write(8'h03, 16'h0000, 1'b0);
  endtask : clear

  task automatic done(input string n);
    $display("test %s finished", n);
  endtask : done

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // roughly 220 cycles are needed; 4000, some eighteen times that, is a hang
  initial begin
    #(40 * 4000);
    mismatches++;
    end_sim();
  end

  // =====================================================================
  // main sequence
  initial begin
    resetn_in = 1'b0;
    enable_pin_in = 1'b0;
    fault_src_in = 8'h00;
    mismatches = 0;
    checked = 0;
    repeat (12) @(negedge clock_in);
    resetn_in = 1'b1;
    foreach (RST_C[i]) begin
      u_host.read(RST_C[i], 1'b0, got);
      chk(got, RST_E[i]);
    end
    clear();
    done("reset values");
    u_host.stop_run();
    foreach (ROWS[i]) begin
      u_host.write(ROWS[i].c, ROWS[i].d, 1'b0);
      u_host.read(ROWS[i].c, 1'b0, got);
      chk(got, ROWS[i].e);
      chk({15'h0000, flt[0]}, {15'h0000, ROWS[i].f});
      clear();
    end
    done("option table");
    chk(ratio, 16'hf004);
    chk({14'h0000, role}, 16'h0001);
    chk({14'h0000, vin_act}, 16'h0003);
    u_host.blk_wr(8'h56, 8'h80);
    u_host.read(8'h56, 1'b0, got);
    chk(got, 16'h0080);
    chk({14'h0000, vin_act}, 16'h0002);
    u_host.write(8'h56, 16'h4002, 1'b1);
    u_host.read(8'h56, 1'b0, got);
    chk(got, 16'h0080);
    chk({15'h0000, flt[0]}, 16'h0001);
    clear();
    u_host.read(8'h19, 1'b1, got);
    chk(got, 16'hb001);
    done("block transfers");
    // a full lock refuses setting writes but still takes its own release
    u_host.write(8'h10, 16'h0080, 1'b0);
    u_host.write(8'h27, 16'hd07d, 1'b0);
    u_host.read(8'h27, 1'b0, got);
    chk(got, 16'hd258);
    chk({15'h0000, flt[0]}, 16'h0001);
    u_host.write(8'h10, 16'h0000, 1'b0);
    clear();
    u_host.read(8'h10, 1'b0, got);
    chk(got, 16'h0000);
    done("write lock");
    @(negedge clock_in) fault_src_in = 8'h02;
    @(negedge clock_in) fault_src_in = 8'h00;
    chk({8'h00, flt}, 16'h0002);
    chk({15'h0000, alert}, 16'h0001);
    u_host.write(8'h1b, 16'h0002, 1'b0);
    chk({15'h0000, alert}, 16'h0000);
    chk({8'h00, flt}, 16'h0002);
    u_host.write(8'h1b, 16'h0000, 1'b0);
    fault_src_in = 8'h04;
    clear();
    chk({8'h00, flt}, 16'h0004);
    chk({15'h0000, alert}, 16'h0001);
    fault_src_in = 8'h00;
    clear();
    chk({8'h00, flt}, 16'h0000);
    chk({15'h0000, alert}, 16'h0000);
    done("faults and alert");
    u_host.crc_send(8'h00, 1'b1);
    u_host.crc_send(8'h01, 1'b0);
    chk({8'h00, pec}, 16'h0007);
    u_host.crc_send(8'h00, 1'b1);
    c = 8'h00;
    foreach (FRAME[i]) begin
      u_host.crc_send(FRAME[i], 1'b0);
      c = crc8(c, FRAME[i]);
    end
    chk({8'h00, pec}, {8'h00, c});
    done("check byte");
    enable_pin_in = 1'b1;
    @(negedge clock_in);
    chk({15'h0000, regulate}, 16'h0001);
    enable_pin_in = 1'b0;
    @(negedge clock_in);
    chk({15'h0000, regulate}, 16'h0000);
    u_host.write(8'h15, 16'h0000, 1'b0);
    u_host.write(8'h16, 16'h0000, 1'b0);
    repeat (2) @(negedge clock_in);
    chk(16'(saves), 16'h0001);
    chk(16'(loads), 16'h0001);
    // command-only start: the run bit alone decides
    u_host.write(8'h02, 16'h0018, 1'b0);
    chk({15'h0000, regulate}, 16'h0000);
    u_host.write(8'h01, 16'h0080, 1'b0);
    chk({15'h0000, regulate}, 16'h0001);
    done("enable pin and store");
    u_host.stop_run();
    u_host.write(8'h27, 16'hd258, 1'b0);
    chk(slew, 16'hd258);
    resetn_in = 1'b0;
    repeat (12) @(negedge clock_in);
    resetn_in = 1'b1;
    u_host.read(8'h27, 1'b0, got);
    chk(got, 16'hd00d);
    chk(slew, 16'hd00d);
    u_host.read(8'h02, 1'b0, got);
    chk(got, 16'h0017);
    chk({15'h0000, regulate}, 16'h0000);
    done("second reset");
    end_sim();
  end
endmodule : tb_top
